// [verilog/scx_defs.vh]
// Constants shared by the subroutine call execution block.
`ifndef SCX_DEFS_VH
`define SCX_DEFS_VH

// ****************************************************************
// Register offsets and fields
// ****************************************************************
`define SCX_OFF_CTRL     12'h000
`define SCX_OFF_STATUS   12'h004
`define SCX_OFF_PC       12'h008
`define SCX_OFF_SPS      12'h00c
`define SCX_OFF_SPL      12'h010
`define SCX_OFF_MEMORY_BASE_UPPER_BYTE    12'h014
`define SCX_OFF_FLAGS    12'h018
`define SCX_OFF_MODE     12'h01c
`define SCX_CTRL_GO      0
`define SCX_CTRL_CLR     1

// ****************************************************************
// Flag positions and reset values
// ****************************************************************
`define SCX_FL_S         7
`define SCX_FL_Z         6
`define SCX_FL_H         4
`define SCX_FL_PV        2
`define SCX_FL_N         1
`define SCX_FL_C         0
`define SCX_RST_PC       24'h000000
`define SCX_RST_SPS      16'h0000
`define SCX_RST_SPL      24'h000000
`define SCX_RST_MEMORY_BASE_UPPER_BYTE    8'h00
`define SCX_RST_FLAGS    8'h00
`define SCX_RST_ADL      1'h0

// ****************************************************************
// Opcodes, prefixes, suffix codes and marker bytes
// ****************************************************************
`define SCX_OP_CALL      8'hcd
`define SCX_OP_CCF       8'h3f
`define SCX_PFX_IS_N     8'h40
`define SCX_PFX_IS_W     8'h49
`define SCX_PFX_IL_N     8'h52
`define SCX_PFX_IL_W     8'h5b
`define SCX_SFX_NONE     2'h0
`define SCX_SFX_SHORT    2'h1
`define SCX_SFX_LONG     2'h2
`define SCX_MARK_NARROW  8'h02
`define SCX_MARK_WIDE    8'h03

// ****************************************************************
// Cycle counts
// ****************************************************************
`define SCX_CC_NONE_N_NT 4'h3
`define SCX_CC_NONE_N_T  4'h6
`define SCX_CC_NONE_W_NT 4'h4
`define SCX_CC_NONE_W_T  4'h7
`define SCX_CC_IS_N_NT   4'h4
`define SCX_CC_IS_N_T    4'h7
`define SCX_CC_IS_W_NT   4'h4
`define SCX_CC_IS_W_T    4'h8
`define SCX_CC_IL_N_NT   4'h5
`define SCX_CC_IL_N_T    4'h8
`define SCX_CC_IL_W_NT   4'h5
`define SCX_CC_IL_W_T    4'h9
`define SCX_UC_NONE_N    4'h5
`define SCX_UC_NONE_W    4'h7
`define SCX_UC_IS_N      4'h7
`define SCX_UC_IS_W      4'h8
`define SCX_UC_IL_N      4'h8
`define SCX_UC_IL_W      4'h9

`endif

// [verilog/scx_cond.v]
// Condition evaluation and cycle budget lookup for call instructions.
`timescale 1ns/1ps
`include "scx_defs.vh"

module scx_cond (
	input  wire [7:0] opcode,
	input  wire [7:0] flags,
	input  wire [1:0] sfx,
	input  wire       wide_address_mode_bit,
	input  wire       uncond,
	input  wire       taken,
	output reg        is_cond,
	output reg        cond_true,
	output reg  [3:0] need
);

	reg flag_sel;

	// ****************************************************************
	// Condition decode
	// ****************************************************************
	always @* begin
		is_cond = (opcode[7:6] == 2'h3) && (opcode[2:0] == 3'h4);
		case (opcode[5:4])
			2'h0: flag_sel = flags[`SCX_FL_Z];
			2'h1: flag_sel = flags[`SCX_FL_C];
			2'h2: flag_sel = flags[`SCX_FL_PV];
			default: flag_sel = flags[`SCX_FL_S];
		endcase
		cond_true = opcode[3] ? flag_sel : ~flag_sel;
	end

	// ****************************************************************
	// Cycle budget
	// ****************************************************************
	always @* begin
		case ({uncond, sfx, wide_address_mode_bit})
			4'h8: need = `SCX_UC_NONE_N;
			4'h9: need = `SCX_UC_NONE_W;
			4'ha: need = `SCX_UC_IS_N;
			4'hb: need = `SCX_UC_IS_W;
			4'hc: need = `SCX_UC_IL_N;
			4'hd: need = `SCX_UC_IL_W;
			4'h0: need = taken ? `SCX_CC_NONE_N_T : `SCX_CC_NONE_N_NT;
			4'h1: need = taken ? `SCX_CC_NONE_W_T : `SCX_CC_NONE_W_NT;
			4'h2: need = taken ? `SCX_CC_IS_N_T : `SCX_CC_IS_N_NT;
			4'h3: need = taken ? `SCX_CC_IS_W_T : `SCX_CC_IS_W_NT;
			4'h4: need = taken ? `SCX_CC_IL_N_T : `SCX_CC_IL_N_NT;
			4'h5: need = taken ? `SCX_CC_IL_W_T : `SCX_CC_IL_W_NT;
			default: need = 4'h0;
		endcase
	end

endmodule // scx_cond

// [verilog/scx_push.v]
// Selection of the byte, stack and count for each push of a call.
`timescale 1ns/1ps
`include "scx_defs.vh"

module scx_push (
	input  wire [1:0]  idx,
	input  wire [1:0]  sfx,
	input  wire        wide_address_mode_bit,
	input  wire [23:0] ret,
	output reg  [2:0]  count,
	output reg         is_long,
	output reg  [7:0]  data
);

	reg [7:0] mark;

	// ****************************************************************
	// Push sequences, most significant byte first except the short wide split push (bits 15:0 before 23:16)
	// ****************************************************************
	always @* begin
		mark = wide_address_mode_bit ? `SCX_MARK_WIDE : `SCX_MARK_NARROW;
		count = 3'h3;
		is_long = 1'h1;
		data = ret[7:0];
		case ({sfx, wide_address_mode_bit})
			3'h0: begin
				count = 3'h2;
				is_long = 1'h0;
				data = (idx == 2'h0) ? ret[15:8] : ret[7:0];
			end
			3'h1: begin
				case (idx)
					2'h0: data = ret[23:16];
					2'h1: data = ret[15:8];
					default: data = ret[7:0];
				endcase
			end
			3'h2: begin
				is_long = (idx == 2'h2);
				case (idx)
					2'h0: data = ret[15:8];
					2'h1: data = ret[7:0];
					default: data = mark;
				endcase
			end
			3'h3: begin
				count = 3'h4;
				is_long = idx[1];
				case (idx)
					2'h0: data = ret[15:8];
					2'h1: data = ret[7:0];
					2'h2: data = ret[23:16];
					default: data = mark;
				endcase
			end
			3'h4: begin
				case (idx)
					2'h0: data = ret[15:8];
					2'h1: data = ret[7:0];
					default: data = mark;
				endcase
			end
			3'h5: begin
				count = 3'h4;
				case (idx)
					2'h0: data = ret[23:16];
					2'h1: data = ret[15:8];
					2'h2: data = ret[7:0];
					default: data = mark;
				endcase
			end
			default: begin
				count = 3'h2;
			end
		endcase
	end

endmodule // scx_push

// [verilog/scx_call_exec.v]
// Call and carry-complement execution unit with APB state registers.
//
// Function
// - Taken call pushes next address, flags kept
// - Target is 16 or 24 bits wide
// - Plain narrow call: short stack, two bytes
// - Plain wide call: long stack, three bytes
// - Short narrow: short push, marker 02h long
// - Short wide: split push, marker 03h, narrow
// - Long narrow: long push, 02h, go wide
// - Long wide: three bytes, 03h, stay wide
// - Opcode selects tested flag and sense
// - Prefix selects suffix; operands low first
// - Unconditional opcode; third byte only wide
// - Conditional call cycle counts per form
// - Carry complement: invert, copy, clear subtract
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
`include "scx_defs.vh"

module scx_call_exec (
	input  wire        pclk,
	input  wire        presetn,
	input  wire [11:0] paddr,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	output reg  [23:0] mem_addr,
	output reg         mem_rd,
	output reg         mem_wr,
	output reg  [7:0]  mem_wdata,
	input  wire [7:0]  mem_rdata
);

	localparam ST_IDLE  = 3'h0;
	localparam ST_FETCH = 3'h1;
	localparam ST_OPND  = 3'h2;
	localparam ST_PUSH  = 3'h3;
	localparam ST_PAD   = 3'h4;

	// ****************************************************************
	// Helper functions
	// ****************************************************************
	function [23:0] fetch_addr;
		input [23:0] pc;
		input        wide_address_mode_bit;
		input [7:0]  mb;
		begin
			fetch_addr = wide_address_mode_bit ? pc : {mb, pc[15:0]};
		end
	endfunction

	function [23:0] pc_step;
		input [23:0] pc;
		input        wide_address_mode_bit;
		begin
			pc_step = wide_address_mode_bit ? pc + 24'h000001 : {pc[23:16], pc[15:0] + 16'h0001};
		end
	endfunction

	// ****************************************************************
	// State
	// ****************************************************************
	reg [2:0]  state_r, state_nxt;
	reg [3:0]  cyc_r, cyc_nxt;
	reg [1:0]  sfx_r, sfx_nxt;
	reg        uncond_r, uncond_nxt;
	reg        taken_r, taken_nxt;
	reg [1:0]  opn_r, opn_nxt;
	reg [1:0]  pidx_r, pidx_nxt;
	reg [23:0] tgt_r, tgt_nxt;
	reg [23:0] pc_r, pc_nxt;
	reg [15:0] sps_r, sps_nxt;
	reg [23:0] spl_r, spl_nxt;
	reg [7:0]  memory_base_upper_byte_r, memory_base_upper_byte_nxt;
	reg [7:0]  flags_r, flags_nxt;
	reg        adl_r, adl_nxt;
	reg        ill_r, ill_nxt;
	reg [7:0]  lop_r, lop_nxt;
	reg [3:0]  lcyc_r, lcyc_nxt;
	reg [23:0] addr_nxt;
	reg        rd_nxt;
	reg        wr_nxt;
	reg [7:0]  wdata_nxt;
	reg [31:0] prdata_nxt;
	reg        pready_nxt;
	reg        pslverr_nxt;
	reg        done_now;
	reg        finish;
	reg        wide;

	wire       is_cond;
	wire       cond_true;
	wire [3:0] need;
	wire [2:0] pcount;
	wire       push_long;
	wire [7:0] push_data;
	wire       idle = (state_r == ST_IDLE);
	wire       apb_wr = psel & penable & pready & pwrite;

	scx_cond u_cond (
		.opcode    (mem_rdata),
		.flags     (flags_r),
		.sfx       (sfx_r),
		.wide_address_mode_bit       (adl_r),
		.uncond    (uncond_r),
		.taken     (taken_r),
		.is_cond   (is_cond),
		.cond_true (cond_true),
		.need      (need)
	);

	scx_push u_push (
		.idx     (pidx_nxt),
		.sfx     (sfx_r),
		.wide_address_mode_bit     (adl_r),
		.ret     (pc_nxt),
		.count   (pcount),
		.is_long (push_long),
		.data    (push_data)
	);

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	always @* begin
		state_nxt = state_r;
		cyc_nxt = idle ? cyc_r : cyc_r + 4'h1;
		sfx_nxt = sfx_r;
		uncond_nxt = uncond_r;
		taken_nxt = taken_r;
		opn_nxt = opn_r;
		pidx_nxt = pidx_r;
		tgt_nxt = tgt_r;
		pc_nxt = pc_r;
		sps_nxt = sps_r;
		spl_nxt = spl_r;
		memory_base_upper_byte_nxt = memory_base_upper_byte_r;
		flags_nxt = flags_r;
		adl_nxt = adl_r;
		ill_nxt = ill_r;
		lop_nxt = lop_r;
		lcyc_nxt = lcyc_r;
		addr_nxt = mem_addr;
		rd_nxt = 1'h0;
		wr_nxt = 1'h0;
		wdata_nxt = mem_wdata;
		done_now = 1'h0;
		finish = 1'h0;
		wide = (sfx_r == `SCX_SFX_LONG) || ((sfx_r == `SCX_SFX_NONE) && adl_r);

		if (apb_wr && (paddr == `SCX_OFF_CTRL) && pwdata[`SCX_CTRL_CLR]) begin
			ill_nxt = 1'h0;
		end
		if (apb_wr && idle) begin
			case (paddr)
				`SCX_OFF_CTRL: begin
					if (pwdata[`SCX_CTRL_GO]) begin
						state_nxt = ST_FETCH;
						cyc_nxt = 4'h1;
						sfx_nxt = `SCX_SFX_NONE;
					end
				end
				`SCX_OFF_PC: pc_nxt = pwdata[23:0];
				`SCX_OFF_SPS: sps_nxt = pwdata[15:0];
				`SCX_OFF_SPL: spl_nxt = pwdata[23:0];
				`SCX_OFF_MEMORY_BASE_UPPER_BYTE: memory_base_upper_byte_nxt = pwdata[7:0];
				`SCX_OFF_FLAGS: flags_nxt = pwdata[7:0];
				`SCX_OFF_MODE: adl_nxt = pwdata[0];
				default: ;
			endcase
		end

		case (state_r)
			ST_FETCH: begin
				pc_nxt = pc_step(pc_r, adl_r);
				lop_nxt = mem_rdata;
				if ((sfx_r == `SCX_SFX_NONE) &&
				    ((mem_rdata == `SCX_PFX_IS_N) || (mem_rdata == `SCX_PFX_IS_W))) begin
					sfx_nxt = `SCX_SFX_SHORT;
				end else if ((sfx_r == `SCX_SFX_NONE) &&
				    ((mem_rdata == `SCX_PFX_IL_N) || (mem_rdata == `SCX_PFX_IL_W))) begin
					sfx_nxt = `SCX_SFX_LONG;
				end else if (mem_rdata == `SCX_OP_CALL) begin
					uncond_nxt = 1'h1;
					taken_nxt = 1'h1;
					opn_nxt = 2'h0;
					state_nxt = ST_OPND;
				end else if (is_cond) begin
					uncond_nxt = 1'h0;
					taken_nxt = cond_true;
					opn_nxt = 2'h0;
					state_nxt = ST_OPND;
				end else if (mem_rdata == `SCX_OP_CCF) begin
					flags_nxt[`SCX_FL_C] = ~flags_r[`SCX_FL_C];
					flags_nxt[`SCX_FL_H] = flags_r[`SCX_FL_C];
					flags_nxt[`SCX_FL_N] = 1'h0;
					finish = 1'h1;
				end else begin
					ill_nxt = 1'h1;
					finish = 1'h1;
				end
			end
			ST_OPND: begin
				pc_nxt = pc_step(pc_r, adl_r);
				case (opn_r)
					2'h0: tgt_nxt = {16'h0000, mem_rdata};
					2'h1: tgt_nxt = {tgt_r[23:16], mem_rdata, tgt_r[7:0]};
					default: tgt_nxt = {mem_rdata, tgt_r[15:0]};
				endcase
				if (opn_r == (wide ? 2'h2 : 2'h1)) begin
					if (taken_r) begin
						pidx_nxt = 2'h0;
						state_nxt = ST_PUSH;
					end else begin
						done_now = 1'h1;
					end
				end else begin
					opn_nxt = opn_r + 2'h1;
				end
			end
			ST_PUSH: begin
				if ({1'h0, pidx_r} == pcount - 3'h1) begin
					done_now = 1'h1;
				end else begin
					pidx_nxt = pidx_r + 2'h1;
				end
			end
			ST_PAD: begin
				done_now = 1'h1;
			end
			default: ;
		endcase

		if (done_now) begin
			if (cyc_r >= need) begin
				finish = 1'h1;
				if (taken_r) begin
					pc_nxt = wide ? tgt_r : {8'h00, tgt_r[15:0]};
					if (sfx_r == `SCX_SFX_LONG) begin
						adl_nxt = 1'h1;
					end else if (sfx_r == `SCX_SFX_SHORT) begin
						adl_nxt = 1'h0;
					end
				end
			end else begin
				state_nxt = ST_PAD;
			end
		end
		if (finish) begin
			state_nxt = ST_IDLE;
			lcyc_nxt = cyc_r;
		end

		case (state_nxt)
			ST_FETCH, ST_OPND: begin
				rd_nxt = 1'h1;
				addr_nxt = fetch_addr(pc_nxt, adl_r, memory_base_upper_byte_r);
			end
			ST_PUSH: begin
				wr_nxt = 1'h1;
				wdata_nxt = push_data;
				if (push_long) begin
					spl_nxt = spl_r - 24'h000001;
					addr_nxt = spl_r - 24'h000001;
				end else begin
					sps_nxt = sps_r - 16'h0001;
					addr_nxt = {memory_base_upper_byte_r, sps_r - 16'h0001};
				end
			end
			default: ;
		endcase
	end

	// ****************************************************************
	// APB read and handshake
	// ****************************************************************
	always @* begin
		prdata_nxt = prdata;
		pslverr_nxt = 1'h0;
		pready_nxt = psel & ~penable & ~pready;
		if (psel && !penable) begin
			case (paddr)
				`SCX_OFF_CTRL: prdata_nxt = 32'h00000000;
				`SCX_OFF_STATUS: prdata_nxt = {12'h000, lcyc_r, lop_r, 6'h00, ill_r, ~idle};
				`SCX_OFF_PC: prdata_nxt = {8'h00, pc_r};
				`SCX_OFF_SPS: prdata_nxt = {16'h0000, sps_r};
				`SCX_OFF_SPL: prdata_nxt = {8'h00, spl_r};
				`SCX_OFF_MEMORY_BASE_UPPER_BYTE: prdata_nxt = {24'h000000, memory_base_upper_byte_r};
				`SCX_OFF_FLAGS: prdata_nxt = {24'h000000, flags_r};
				`SCX_OFF_MODE: prdata_nxt = {31'h00000000, adl_r};
				default: begin
					prdata_nxt = 32'h00000000;
					pslverr_nxt = 1'h1;
				end
			endcase
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_IDLE;
			cyc_r <= 4'h0;
			sfx_r <= `SCX_SFX_NONE;
			uncond_r <= 1'h0;
			taken_r <= 1'h0;
			opn_r <= 2'h0;
			pidx_r <= 2'h0;
			tgt_r <= 24'h000000;
			pc_r <= `SCX_RST_PC;
			sps_r <= `SCX_RST_SPS;
			spl_r <= `SCX_RST_SPL;
			memory_base_upper_byte_r <= `SCX_RST_MEMORY_BASE_UPPER_BYTE;
			flags_r <= `SCX_RST_FLAGS;
			adl_r <= `SCX_RST_ADL;
			ill_r <= 1'h0;
			lop_r <= 8'h00;
			lcyc_r <= 4'h0;
			mem_addr <= 24'h000000;
			mem_rd <= 1'h0;
			mem_wr <= 1'h0;
			mem_wdata <= 8'h00;
			prdata <= 32'h00000000;
			pready <= 1'h0;
			pslverr <= 1'h0;
		end else begin
			state_r <= state_nxt;
			cyc_r <= cyc_nxt;
			sfx_r <= sfx_nxt;
			uncond_r <= uncond_nxt;
			taken_r <= taken_nxt;
			opn_r <= opn_nxt;
			pidx_r <= pidx_nxt;
			tgt_r <= tgt_nxt;
			pc_r <= pc_nxt;
			sps_r <= sps_nxt;
			spl_r <= spl_nxt;
			memory_base_upper_byte_r <= memory_base_upper_byte_nxt;
			flags_r <= flags_nxt;
			adl_r <= adl_nxt;
			ill_r <= ill_nxt;
			lop_r <= lop_nxt;
			lcyc_r <= lcyc_nxt;
			mem_addr <= addr_nxt;
			mem_rd <= rd_nxt;
			mem_wr <= wr_nxt;
			mem_wdata <= wdata_nxt;
			prdata <= prdata_nxt;
			pready <= pready_nxt;
			pslverr <= pslverr_nxt;
		end
	end

endmodule // scx_call_exec

// [test/scx_call_props.sv]
// Concurrent checks on the ports of the call execution unit.
`timescale 1ns/1ps
module scx_call_props (
	input logic        pclk,
	input logic        presetn,
	input logic        psel,
	input logic        penable,
	input logic        pready,
	input logic [23:0] mem_addr,
	input logic        mem_rd,
	input logic        mem_wr,
	input logic [7:0]  mem_wdata,
	input logic [7:0]  mem_rdata
);
	logic       rd_q;
	logic [7:0] first_r;
	logic [2:0] wr_n;
	wire        start = mem_rd && !rd_q;
	wire        long_r = first_r == 8'h52 || first_r == 8'h5b;
	wire        pfx_r = long_r || first_r == 8'h40 || first_r == 8'h49;
	function automatic logic is_call(input logic [7:0] b);
		return b == 8'hcd || (b[7:6] == 2'b11 && b[2:0] == 3'b100);
	endfunction
	// Helper state remembers the first byte and push count of each instruction.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_q <= 1'b0;
			first_r <= 8'h00;
			wr_n <= 3'h0;
		end else begin
			rd_q <= mem_rd;
			if (start)
				first_r <= mem_rdata;
			if (start)
				wr_n <= 3'h0;
			else if (mem_wr)
				wr_n <= wr_n + 3'h1;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_pfx(lo, hi);
		start && (mem_rdata == lo || mem_rdata == hi) ##1 is_call(mem_rdata);
	endsequence
	property p_apb_answer;
		psel && !penable |=> pready;
	endproperty
	a_apb_answer: assert property (p_apb_answer)
		else $error("APB access cycle without ready");
	property p_fetch_step;
		mem_rd && rd_q |-> mem_addr[15:0] == $past(mem_addr[15:0]) + 16'h1;
	endproperty
	a_fetch_step: assert property (p_fetch_step)
		else $error("Instruction bytes not fetched in sequence");
	property p_push_last;
		mem_wr |=> !mem_rd;
	endproperty
	a_push_last: assert property (p_push_last)
		else $error("Fetch after a push");
	property p_long_fetch;
		s_pfx(8'h52, 8'h5b) |=> mem_rd [*3] ##1 !mem_rd;
	endproperty
	a_long_fetch: assert property (p_long_fetch)
		else $error("Long call operand fetch count wrong");
	property p_short_fetch;
		s_pfx(8'h40, 8'h49) |=> mem_rd [*2] ##1 !mem_rd;
	endproperty
	a_short_fetch: assert property (p_short_fetch)
		else $error("Short call operand fetch count wrong");
	property p_marker;
		$past(mem_wr) && !mem_wr && pfx_r |-> $past(mem_wdata) == {7'h01, first_r[0]};
	endproperty
	a_marker: assert property (p_marker)
		else $error("Last push of a suffixed call is not the marker");
	property p_push_count;
		$past(mem_wr) && !mem_wr && pfx_r |-> wr_n == (first_r[0] ? 3'h4 : 3'h3);
	endproperty
	a_push_count: assert property (p_push_count)
		else $error("Suffixed call push count wrong");
	property p_long_dec;
		mem_wr && $past(mem_wr) && long_r |-> mem_addr == $past(mem_addr) - 24'h1;
	endproperty
	a_long_dec: assert property (p_long_dec)
		else $error("Long stack push not pre-decremented");
	property p_plain_dec;
		mem_wr && $past(mem_wr) && is_call(first_r) |->
			mem_addr[15:0] == $past(mem_addr[15:0]) - 16'h1;
	endproperty
	a_plain_dec: assert property (p_plain_dec)
		else $error("Plain call push not pre-decremented");
endmodule // scx_call_props
bind scx_call_exec scx_call_props scx_call_props_inst (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pready(pready), .mem_addr(mem_addr), .mem_rd(mem_rd),
	.mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

// [test/scx_mem_model.sv]
// Behavioural program and stack memory on the core bus.
`timescale 1ns/1ps
module scx_mem_model (
	input  logic        pclk,
	input  logic [23:0] mem_addr,
	input  logic        mem_rd,
	input  logic        mem_wr,
	input  logic [7:0]  mem_wdata,
	output logic [7:0]  mem_rdata
);
	logic [7:0] mem [int];
	always @(posedge pclk) begin
		if (mem_wr)
			mem[mem_addr] = mem_wdata;
	end
	// Outside a fetch the data lines carry a changing pattern.
	always @(mem_addr or mem_rd) begin
		if (mem_rd && mem.exists(mem_addr))
			mem_rdata = mem[mem_addr];
		else
			mem_rdata = ~mem_addr[7:0];
	end
endmodule // scx_mem_model

// [test/subroutine_call_execution_tb.sv]
// Self-checking bench for the call and carry-complement execution unit.
`timescale 1ns/1ps
`include "scx_defs.vh"
module subroutine_call_execution_tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_rd, mem_wr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic [23:0] mem_addr, pc, long_stack_pointer, espl, fa, ret, epc;
	logic [15:0] short_stack_pointer, esps;
	logic [7:0]  mem_wdata, mem_rdata, mb, fl, op, t0, t1, t2;
	logic        errv, wide_address_mode_bit, take, wide;
	integer      fails = 0, checks = 0, seed = 32'h569e64c2, k, f, sfx;
	int          uc[6] = '{5, 7, 7, 8, 8, 9}, ct[6] = '{6, 7, 7, 8, 8, 9};
	int          cn[6] = '{3, 4, 4, 4, 5, 5}, bp[4] = '{6, 0, 2, 7};
	logic [23:0] qa[$];
	logic [7:0]  qd[$], ib[$];
	scx_call_exec scx_call_exec_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
	scx_mem_model scx_mem_model_inst (.pclk(pclk), .mem_addr(mem_addr), .mem_rd(mem_rd),
		.mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks = checks + 1;
		if (seen !== exp) begin
			fails = fails + 1;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		integer n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n = n + 1;
		end while (pready !== 1'b1 && n < 16);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			fails = fails + 1;
			tally_and_finish;
		end
		@(posedge pclk);
	endtask
	task run(input logic [23:0] p, input logic [7:0] fv, input logic m);
		integer n;
		apb(1'b1, `SCX_OFF_PC, {8'h00, p});
		apb(1'b1, `SCX_OFF_SPS, {16'h0000, short_stack_pointer});
		apb(1'b1, `SCX_OFF_SPL, {8'h00, long_stack_pointer});
		apb(1'b1, `SCX_OFF_MEMORY_BASE_UPPER_BYTE, {24'h000000, mb});
		apb(1'b1, `SCX_OFF_FLAGS, {24'h000000, fv});
		apb(1'b1, `SCX_OFF_MODE, {31'h0, m});
		apb(1'b1, `SCX_OFF_CTRL, 32'h00000001);
		n = 0;
		do begin
			apb(1'b0, `SCX_OFF_STATUS, 32'h0);
			n = n + 1;
		end while (rdv[0] !== 1'b0 && n < 16);
		if (rdv[0] !== 1'b0) begin
			fails = fails + 1;
			tally_and_finish;
		end
	endtask
	task push(input logic on_long, input logic [7:0] d);
		if (on_long) begin
			espl = espl - 24'h1;
			qa.push_back(espl);
		end else begin
			esps = esps - 16'h1;
			qa.push_back({mb, esps});
		end
		qd.push_back(d);
	endtask
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (k = 0; k < 32; k = k + 4) begin
			apb(1'b0, k[11:0], 32'h0);
			chk(rdv, 32'h0);
		end
		apb(1'b1, 12'h020, 32'hffffffff);
		chk({31'h0, errv}, 32'h1);
		apb(1'b0, 12'h020, 32'h0);
		chk({errv, rdv[30:0]}, 32'h80000000);
		$display("reset values and unmapped access done");
		for (k = 0; k < 54; k = k + 1) begin
			f = k % 6;
			sfx = f / 2;
			wide_address_mode_bit = f[0];
			op = (k < 6) ? 8'hcd : {2'b11, k[2:0], 3'b100};
			pc = {wide_address_mode_bit ? 8'($random(seed)) : 8'h00, 4'h1, 12'($random(seed))};
			short_stack_pointer = {4'h8, 12'($random(seed))};
			long_stack_pointer = {8'($random(seed)), 8'h95, 8'($random(seed))};
			{mb, fl, t0, t1} = $random(seed);
			t2 = $random(seed);
			wide = sfx == 2 || (sfx == 0 && wide_address_mode_bit);
			fa = wide_address_mode_bit ? pc : {mb, pc[15:0]};
			ib = {};
			if (sfx != 0)
				ib.push_back(8'(64 + 18 * (sfx - 1) + 9 * wide_address_mode_bit));
			ib.push_back(op);
			ib.push_back(t0);
			ib.push_back(t1);
			if (wide)
				ib.push_back(t2);
			scx_mem_model_inst.mem.delete();
			foreach (ib[j])
				scx_mem_model_inst.mem[fa + j] = ib[j];
			ret = pc + 24'(ib.size());
			take = op == 8'hcd || fl[bp[op[5:4]]] == op[3];
			esps = short_stack_pointer;
			espl = long_stack_pointer;
			qa = {};
			qd = {};
			if (take && sfx == 1) begin
				push(1'b0, ret[15:8]);
				push(1'b0, ret[7:0]);
				if (wide_address_mode_bit)
					push(1'b1, ret[23:16]);
				push(1'b1, {7'h01, wide_address_mode_bit});
			end else if (take && (sfx == 2 || wide_address_mode_bit)) begin
				if (wide_address_mode_bit)
					push(1'b1, ret[23:16]);
				push(1'b1, ret[15:8]);
				push(1'b1, ret[7:0]);
				if (sfx == 2)
					push(1'b1, {7'h01, wide_address_mode_bit});
			end else if (take) begin
				push(1'b0, ret[15:8]);
				push(1'b0, ret[7:0]);
			end
			epc = !take ? ret : wide ? {t2, t1, t0} : {8'h00, t1, t0};
			run(pc, fl, wide_address_mode_bit);
			chk({28'h0, rdv[19:16]}, !take ? cn[f] : op == 8'hcd ? uc[f] : ct[f]);
			apb(1'b0, `SCX_OFF_PC, 32'h0);
			chk(rdv, {8'h00, epc});
			apb(1'b0, `SCX_OFF_SPS, 32'h0);
			chk(rdv, {16'h0000, esps});
			apb(1'b0, `SCX_OFF_SPL, 32'h0);
			chk(rdv, {8'h00, espl});
			apb(1'b0, `SCX_OFF_MODE, 32'h0);
			chk(rdv, {31'h0, take && sfx != 0 ? sfx == 2 : wide_address_mode_bit});
			apb(1'b0, `SCX_OFF_FLAGS, 32'h0);
			chk(rdv, {24'h0, fl});
			chk(scx_mem_model_inst.mem.num(), ib.size() + qd.size());
			foreach (qa[j])
				chk(scx_mem_model_inst.mem[qa[j]], qd[j]);
		end
		$display("call forms and conditions done");
		for (k = 0; k < 4; k = k + 1) begin
			{mb, fl} = $random(seed);
			pc = 24'h001200;
			scx_mem_model_inst.mem.delete();
			scx_mem_model_inst.mem[{mb, pc[15:0]}] = 8'h3f;
			run(pc, fl, 1'b0);
			chk({28'h0, rdv[19:16]}, 32'h1);
			apb(1'b0, `SCX_OFF_FLAGS, 32'h0);
			chk(rdv, {24'h0, fl[7:5], fl[0], fl[3:2], 1'b0, ~fl[0]});
		end
		$display("carry complement done");
		mb = 8'h00;
		scx_mem_model_inst.mem.delete();
		scx_mem_model_inst.mem[24'h001200] = 8'h40;
		scx_mem_model_inst.mem[24'h001201] = 8'h52;
		run(24'h001200, 8'h00, 1'b0);
		chk({12'h000, rdv[19:0]}, 32'h00025202);
		apb(1'b1, `SCX_OFF_CTRL, 32'h00000002);
		apb(1'b0, `SCX_OFF_STATUS, 32'h0);
		chk({30'h0, rdv[1:0]}, 32'h0);
		$display("second prefix and clear done");
		tally_and_finish;
	end
endmodule // subroutine_call_execution_tb
